// ==== rtl/sioc_config_regs.sv ====
// configuration registers 04 to 09 of the multi-function I/O controller
// Functional notes
// - first UART outputs float when its float bit set and powered down
// - second UART outputs float when its float bit set and powered down
// - four-bit ECP FIFO threshold held in low nibble, zero at reset
// - two-drive mode: motor bit and select pick drive A or B pins
// - four-drive mode: with the selected motor bit set, motor pins low, select pins carry drive number
// - floppy input pull-ups on while pull-up-off bit is clear
// - floppy power-down bit puts the floppy controller in power-down
// - floppy outputs float when float bit set and controller powered down
// - four two-bit drive types; code 00 is normal rate-driven operation
// - three-mode codes 01, 10, 11 select 1.2M, 1.44M, 720K drives
// - write-disable forces write-enable and write-data pins high
// - soft write-protect reports protected, else follows the pin
// - media id and boot drive stored in bits 3:2 and 1:0
// - parallel mode high bit joins two low bits into a three-bit mode
// - lock bit blocks data port reads and writes except to the lock register
// - three-mode bit gates drive types and opens the tape register
// - tape register bits 5:4 override the reduced-write-current pin
// - low nibble of lock register reads a fixed chip id
// - unlock, write index to index port, then use the data port
// - registers other than the index and the access window reset only on cold reset, never on warm reset
// - parallel mode decode with codes 010 and 100 reserved
`timescale 1ns/10ps
`default_nettype none
`include "sioc_map.svh"
module sioc_config_regs #(
    // identification value is arbitrary
    parameter logic [3:0] CHIP_ID = 4'h6
) (
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       warm_rst_in,
    input  wire logic [11:0] io_addr_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire logic [7:0] io_wdata_in,
    output var  logic [7:0] io_rdata_out,
    input  wire logic [7:0] fdc_dor_in,
    input  wire logic       fdc_we_n_in,
    input  wire logic       fdc_wd_n_in,
    input  wire logic       fdc_high_rate_in,
    input  wire logic       wp_pin_n_in,
    input  wire logic [1:0] prt_mode_low_in,
    output var  logic       motor_a_pin_out,
    output var  logic       motor_b_pin_out,
    output var  logic       drive_select_a_pin_out,
    output var  logic       drive_select_b_pin_out,
    output var  logic       write_enable_n_out,
    output var  logic       write_data_pin_out,
    output var  logic       reduced_write_current_pin_out,
    output var  logic       floppy_pins_oe_out,
    output var  logic       write_protect_out,
    output var  logic       floppy_pullup_en_out,
    output var  logic       floppy_power_down_out,
    output var  logic       uart_a_power_down_out,
    output var  logic       uart_b_power_down_out,
    output var  logic       uart_a_oe_out,
    output var  logic       uart_b_oe_out,
    output var  logic       par_power_down_out,
    output var  logic       par_oe_out,
    output var  logic [2:0] par_mode_out,
    output var  logic       par_mode_rsvd_out,
    output var  logic [3:0] ecp_fifo_level_out,
    output var  logic [1:0] media_id_out,
    output var  logic [1:0] boot_drive_out,
    output var  logic [1:0] drive_type_out,
    output var  logic       three_mode_enable_out,
    output var  logic       config_open_out
);
    // ************************************************************
    // register state
    // ************************************************************
    sioc_pkg::sioc_acc_t acc;
    sioc_pkg::sioc_acc_t next_acc;
    logic [7:0] index;
    logic [7:0] next_index;
    logic [7:0] pwr;
    logic [7:0] next_pwr;
    logic [7:0] ecp;
    logic [7:0] next_ecp;
    logic [7:0] drv;
    logic [7:0] next_drv;
    logic [7:0] dtype;
    logic [7:0] next_dtype;
    logic [7:0] wrm;
    logic [7:0] next_wrm;
    logic [7:0] lockm;
    logic [7:0] next_lockm;
    logic [7:0] tape;
    logic [7:0] next_tape;
    logic [7:0] next_rdata;
    logic       locked;
    logic       three_mode;
    logic       data_ok;

    always_comb begin
        locked     = lockm[`SIOC_LOCK_BIT];
        three_mode = lockm[`SIOC_THREE_MODE];
        // the lock register stays reachable so software can clear it
        data_ok    = acc == sioc_pkg::SIOC_OPEN &&
                     (!locked || index == `SIOC_IDX_LOCK);
    end

    always_comb begin
        next_acc   = acc;
        next_index = index;
        next_pwr   = pwr;
        next_ecp   = ecp;
        next_drv   = drv;
        next_dtype = dtype;
        next_wrm   = wrm;
        next_lockm = lockm;
        next_tape  = tape;
        if (io_wr_in) begin
            if (io_addr_in == `SIOC_UNLOCK_PORT) begin
                // any other value closes the window again
                if (io_wdata_in == `SIOC_UNLOCK_VAL) begin
                    next_acc = sioc_pkg::SIOC_OPEN;
                end else begin
                    next_acc = sioc_pkg::SIOC_CLOSED;
                end
            end else if (io_addr_in == `SIOC_INDEX_PORT &&
                         acc == sioc_pkg::SIOC_OPEN) begin
                next_index = io_wdata_in;
            end else if (io_addr_in == `SIOC_DATA_PORT && data_ok) begin
                if (index == `SIOC_IDX_PWR) begin
                    next_pwr = io_wdata_in & `SIOC_PWR_MASK;
                end else if (index == `SIOC_IDX_ECP) begin
                    next_ecp = io_wdata_in & `SIOC_ECP_MASK;
                end else if (index == `SIOC_IDX_DRV) begin
                    next_drv = io_wdata_in & `SIOC_DRV_MASK;
                end else if (index == `SIOC_IDX_TYPE) begin
                    next_dtype = io_wdata_in & `SIOC_TYPE_MASK;
                end else if (index == `SIOC_IDX_WRM) begin
                    next_wrm = io_wdata_in & `SIOC_WRM_MASK;
                end else if (index == `SIOC_IDX_LOCK) begin
                    // chip id bits are not stored at all
                    next_lockm = io_wdata_in & `SIOC_LOCK_MASK;
                end
            end else if (io_addr_in == `SIOC_TAPE_PORT && three_mode) begin
                next_tape = io_wdata_in & `SIOC_TAPE_MASK;
            end
        end
        // warm reset shuts the access window and clears the index
        if (warm_rst_in) begin
            next_acc   = sioc_pkg::SIOC_CLOSED;
            next_index = `SIOC_RST_VAL;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc   <= sioc_pkg::SIOC_CLOSED;
            index <= `SIOC_RST_VAL;
            pwr   <= `SIOC_RST_VAL;
            ecp   <= `SIOC_RST_VAL;
            drv   <= `SIOC_RST_VAL;
            dtype <= `SIOC_RST_VAL;
            wrm   <= `SIOC_RST_VAL;
            lockm <= `SIOC_RST_VAL;
            tape  <= `SIOC_RST_VAL;
        end else begin
            acc   <= next_acc;
            index <= next_index;
            pwr   <= next_pwr;
            ecp   <= next_ecp;
            drv   <= next_drv;
            dtype <= next_dtype;
            wrm   <= next_wrm;
            lockm <= next_lockm;
            tape  <= next_tape;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        next_rdata = io_rdata_out;
        if (io_rd_in) begin
            next_rdata = 8'h00;
            if (io_addr_in == `SIOC_DATA_PORT && data_ok) begin
                if (index == `SIOC_IDX_PWR) begin
                    next_rdata = pwr;
                end else if (index == `SIOC_IDX_ECP) begin
                    next_rdata = ecp;
                end else if (index == `SIOC_IDX_DRV) begin
                    next_rdata = drv;
                end else if (index == `SIOC_IDX_TYPE) begin
                    next_rdata = dtype;
                end else if (index == `SIOC_IDX_WRM) begin
                    next_rdata = wrm;
                end else if (index == `SIOC_IDX_LOCK) begin
                    next_rdata = {lockm[7:4], CHIP_ID};
                end
            end else if (io_addr_in == `SIOC_TAPE_PORT && three_mode) begin
                next_rdata = tape;
            end
        end
    end

    // ************************************************************
    // drive pin encoding and per-drive types
    // ************************************************************
    sioc_drv_if drv_bus ();
    sioc_drive_enc u_enc (
        .drv (drv_bus.enc)
    );
    assign drv_bus.four_mode = drv[`SIOC_FOUR_DRV];
    assign drv_bus.dor       = fdc_dor_in;

    logic [1:0] type_of [4];
    for (genvar g = 0; g < 4; g++) begin : g_type
        assign type_of[g] = dtype[2*g+:2];
    end

    // ************************************************************
    // output stage
    // ************************************************************
    logic [1:0] next_type;
    logic       next_rwc;
    logic       fdc_float;
    logic [2:0] next_mode;
    always_comb begin
        next_type = type_of[fdc_dor_in[1:0]];
        next_rwc  = fdc_high_rate_in;
        if (three_mode) begin
            // tape register setting wins over the drive type field
            if (tape[5:4] == 2'b01) begin
                next_rwc = 1'b0;
            end else if (tape[5:4] == 2'b10) begin
                next_rwc = 1'b1;
            end else if (next_type == 2'b01) begin
                next_rwc = 1'b0;
            end else if (next_type == 2'b10) begin
                next_rwc = 1'b1;
            end
        end
        fdc_float = drv[`SIOC_FDC_FLOAT] && drv[`SIOC_FDC_PWD];
        next_mode = {lockm[`SIOC_PAR_HIGH], prt_mode_low_in};
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            io_rdata_out                  <= 8'h00;
            motor_a_pin_out               <= 1'b1;
            motor_b_pin_out               <= 1'b1;
            drive_select_a_pin_out        <= 1'b1;
            drive_select_b_pin_out        <= 1'b1;
            write_enable_n_out            <= 1'b1;
            write_data_pin_out            <= 1'b1;
            reduced_write_current_pin_out <= 1'b0;
            floppy_pins_oe_out            <= 1'b1;
            write_protect_out             <= 1'b0;
            floppy_pullup_en_out          <= 1'b1;
            floppy_power_down_out         <= 1'b0;
            uart_a_power_down_out         <= 1'b0;
            uart_b_power_down_out         <= 1'b0;
            uart_a_oe_out                 <= 1'b1;
            uart_b_oe_out                 <= 1'b1;
            par_power_down_out            <= 1'b0;
            par_oe_out                    <= 1'b1;
            par_mode_out                  <= 3'h0;
            par_mode_rsvd_out             <= 1'b0;
            ecp_fifo_level_out            <= 4'h0;
            media_id_out                  <= 2'h0;
            boot_drive_out                <= 2'h0;
            drive_type_out                <= 2'h0;
            three_mode_enable_out         <= 1'b0;
            config_open_out               <= 1'b0;
        end else begin
            io_rdata_out           <= next_rdata;
            motor_a_pin_out        <= drv_bus.motor_a;
            motor_b_pin_out        <= drv_bus.motor_b;
            drive_select_a_pin_out <= drv_bus.ds_a;
            drive_select_b_pin_out <= drv_bus.ds_b;
            write_enable_n_out     <= fdc_we_n_in | wrm[`SIOC_WR_DIS];
            write_data_pin_out     <= fdc_wd_n_in | wrm[`SIOC_WR_DIS];
            reduced_write_current_pin_out <= next_rwc;
            floppy_pins_oe_out     <= !fdc_float;
            write_protect_out      <= wrm[`SIOC_SOFT_WP] | !wp_pin_n_in;
            floppy_pullup_en_out   <= !drv[`SIOC_PULLUP_OFF];
            floppy_power_down_out  <= drv[`SIOC_FDC_PWD];
            uart_a_power_down_out  <= pwr[`SIOC_UA_PWD];
            uart_b_power_down_out  <= pwr[`SIOC_UB_PWD];
            uart_a_oe_out          <= !(pwr[`SIOC_UA_FLOAT] &&
                                        pwr[`SIOC_UA_PWD]);
            uart_b_oe_out          <= !(pwr[`SIOC_UB_FLOAT] &&
                                        pwr[`SIOC_UB_PWD]);
            par_power_down_out     <= pwr[`SIOC_PRT_PWD];
            par_oe_out             <= !(pwr[`SIOC_PRT_FLOAT] &&
                                        pwr[`SIOC_PRT_PWD]);
            par_mode_out           <= next_mode;
            par_mode_rsvd_out      <= next_mode ==
                                          sioc_pkg::SIOC_PAR_RSVD_2 ||
                                      next_mode ==
                                          sioc_pkg::SIOC_PAR_RSVD_4;
            ecp_fifo_level_out     <= ecp[3:0];
            media_id_out           <= wrm[3:2];
            boot_drive_out         <= wrm[1:0];
            drive_type_out         <= next_type;
            three_mode_enable_out  <= three_mode;
            config_open_out        <= acc == sioc_pkg::SIOC_OPEN;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    uart_a_float_a: assert property (
        pwr[`SIOC_UA_FLOAT] && pwr[`SIOC_UA_PWD] |=> !uart_a_oe_out)
        else $error("uart a not floated");
    uart_b_float_a: assert property (
        !pwr[`SIOC_UB_FLOAT] |=> uart_b_oe_out)
        else $error("uart b floated while float bit clear");
    fdc_float_a: assert property (
        floppy_pins_oe_out == !($past(drv[`SIOC_FDC_FLOAT]) &&
                                $past(drv[`SIOC_FDC_PWD])))
        else $error("floppy float mismatch");
    two_drive_a: assert property (
        !drv[`SIOC_FOUR_DRV] && fdc_dor_in[5:4] == 2'b10 &&
        fdc_dor_in[1:0] == 2'b01
        |=> !motor_b_pin_out && !drive_select_b_pin_out &&
            motor_a_pin_out && drive_select_a_pin_out)
        else $error("two drive select of b wrong");
    four_drive_a: assert property (
        drv[`SIOC_FOUR_DRV] && fdc_dor_in[7] && fdc_dor_in[1:0] == 2'b11
        |=> !motor_a_pin_out && !motor_b_pin_out &&
            drive_select_a_pin_out && drive_select_b_pin_out)
        else $error("four drive select of d wrong");
    write_disable_a: assert property (
        wrm[`SIOC_WR_DIS] |=> write_enable_n_out && write_data_pin_out)
        else $error("write pins active while disabled");
    soft_protect_a: assert property (
        !wrm[`SIOC_SOFT_WP] |=> write_protect_out == !$past(wp_pin_n_in))
        else $error("write protect not following pin");
    lock_blocks_a: assert property (
        locked && io_wr_in && io_addr_in == `SIOC_DATA_PORT &&
        index == `SIOC_IDX_ECP |=> $stable(ecp))
        else $error("locked register written");
    chip_id_a: assert property (
        io_rd_in && io_addr_in == `SIOC_DATA_PORT && data_ok &&
        index == `SIOC_IDX_LOCK |=> io_rdata_out[3:0] == CHIP_ID)
        else $error("chip id wrong");
    warm_keep_a: assert property (
        warm_rst_in && !io_wr_in |=> $stable(dtype) &&
        acc == sioc_pkg::SIOC_CLOSED ##1 !config_open_out)
        else $error("warm reset disturbed registers");
    tape_rwc_a: assert property (
        three_mode && tape[5:4] == 2'b01 |=> !reduced_write_current_pin_out)
        else $error("tape register rwc override missing");
endmodule
`default_nettype wire

// ==== rtl/sioc_map.svh ====
// offsets, field positions, reset values and port codes of the config slice
`ifndef SIOC_MAP_SVH
`define SIOC_MAP_SVH
// ************************************************************
// host port addresses and unlock code
// ************************************************************
`define SIOC_UNLOCK_PORT 12'h250
`define SIOC_INDEX_PORT  12'h251
`define SIOC_DATA_PORT   12'h252
`define SIOC_TAPE_PORT   12'h3F3
`define SIOC_UNLOCK_VAL  8'h89
// ************************************************************
// register indexes
// ************************************************************
`define SIOC_IDX_PWR     8'h04
`define SIOC_IDX_ECP     8'h05
`define SIOC_IDX_DRV     8'h06
`define SIOC_IDX_TYPE    8'h07
`define SIOC_IDX_WRM     8'h08
`define SIOC_IDX_LOCK    8'h09
// ************************************************************
// writable masks and reset values
// ************************************************************
`define SIOC_PWR_MASK    8'hBB
`define SIOC_ECP_MASK    8'h0F
`define SIOC_DRV_MASK    8'h3A
`define SIOC_TYPE_MASK   8'hFF
`define SIOC_WRM_MASK    8'h3F
`define SIOC_LOCK_MASK   8'hE0
`define SIOC_TAPE_MASK   8'h30
`define SIOC_RST_VAL     8'h00
// ************************************************************
// field positions
// ************************************************************
`define SIOC_PRT_PWD     7
`define SIOC_UA_PWD      5
`define SIOC_UB_PWD      4
`define SIOC_PRT_FLOAT   3
`define SIOC_UA_FLOAT    1
`define SIOC_UB_FLOAT    0
`define SIOC_FOUR_DRV    5
`define SIOC_PULLUP_OFF  4
`define SIOC_FDC_PWD     3
`define SIOC_FDC_FLOAT   1
`define SIOC_WR_DIS      5
`define SIOC_SOFT_WP     4
`define SIOC_PAR_HIGH    7
`define SIOC_LOCK_BIT    6
`define SIOC_THREE_MODE  5
`endif

// ==== rtl/sioc_pkg.sv ====
// types shared by the config slice modules
package sioc_pkg;
    typedef enum logic {
        SIOC_CLOSED,
        SIOC_OPEN
    } sioc_acc_t;
    // order gives the three-bit selector value
    typedef enum logic [2:0] {
        SIOC_PAR_NORMAL,
        SIOC_PAR_EXT_FLOPPY,
        SIOC_PAR_RSVD_2,
        SIOC_PAR_EXT_TWO,
        SIOC_PAR_RSVD_4,
        SIOC_PAR_EPP_SPP,
        SIOC_PAR_ECP,
        SIOC_PAR_ECP_EPP
    } sioc_par_mode_t;
endpackage

// ==== rtl/sioc_drv_if.sv ====
// drive select and motor pin encoding signals
`timescale 1ns/10ps
`default_nettype none
interface sioc_drv_if;
    logic       four_mode;
    logic [7:0] dor;
    logic       motor_a;
    logic       motor_b;
    logic       ds_a;
    logic       ds_b;
    modport enc (input four_mode, dor,
                 output motor_a, motor_b, ds_a, ds_b);
    modport user (output four_mode, dor,
                  input motor_a, motor_b, ds_a, ds_b);
endinterface
`default_nettype wire

// ==== rtl/sioc_drive_enc.sv ====
// two- and four-drive motor and select pin encoder
`timescale 1ns/10ps
`default_nettype none
module sioc_drive_enc (
    sioc_drv_if.enc drv
);
    logic [1:0] sel;
    logic       sel_motor;
    always_comb begin
        sel       = drv.dor[1:0];
        sel_motor = drv.dor[3'(4) + 3'(sel)];
        drv.motor_a = 1'b1;
        drv.motor_b = 1'b1;
        drv.ds_a    = 1'b1;
        drv.ds_b    = 1'b1;
        if (drv.four_mode) begin
            // pins carry a binary drive number plus a shared motor line
            if (sel_motor) begin
                drv.motor_a = 1'b0;
                drv.motor_b = 1'b0;
                drv.ds_a    = sel[0];
                drv.ds_b    = sel[1];
            end
        end else if (drv.dor[4] && sel == 2'b00) begin
            drv.motor_a = 1'b0;
            drv.ds_a    = 1'b0;
        end else if (drv.dor[5] && sel == 2'b01) begin
            drv.motor_b = 1'b0;
            drv.ds_b    = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/sioc_fdd_model.sv ====
// floppy drive cable model answering write-protect for the selected drive
`timescale 1ns/10ps
`default_nettype none
module sioc_fdd_model #(
    parameter logic [3:0] WP_DRIVES = 4'b0010
) (
    input  wire logic four_mode_in,
    input  wire logic motor_a_n_in,
    input  wire logic motor_b_n_in,
    input  wire logic ds_a_n_in,
    input  wire logic ds_b_n_in,
    output var  logic wp_n_out
);
    // ****************************************************
    // drive decode and write-protect answer
    // ****************************************************
    logic [1:0] sel;
    logic       act;
    always_comb begin
        if (four_mode_in) begin
            sel = {ds_b_n_in, ds_a_n_in};
            act = ~motor_a_n_in;
        end else begin
            sel = {1'b0, ~ds_b_n_in};
            act = ~ds_a_n_in | ~ds_b_n_in;
        end
        // the line has a pull-up, so no selected drive reads high
        wp_n_out = act ? ~WP_DRIVES[sel] : 1'b1;
    end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the configuration register slice
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk_sys_in = 1'b0, sys_rst_in = 1'b1, warm_rst_in = 1'b0;
    logic [11:0] io_addr_in = 12'h000;
    logic        io_wr_in = 1'b0, io_rd_in = 1'b0;
    logic [7:0]  io_wdata_in = 8'h00, io_rdata_out, fdc_dor_in = 8'h00;
    logic        we_n = 1'b1, wd_n = 1'b1, hi_rate = 1'b0, wp_n;
    logic [1:0]  pm_low = 2'b00, media, boot, dtype;
    logic        ma, mb, da, db, we_o, wd_o, reduced_write_current_pin, oe, wp, pu, pwd, tm;
    logic [2:0]  par_mode;
    logic [3:0]  ecp;
    logic [7:0]  d;
    logic        ua_pd, ua_oe, ub_pd, ub_oe, p_pd, p_oe, p_rsvd, opn;
    logic        four = 1'b0;
    int          num_errors = 0, n_checks = 0;
    sioc_config_regs dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .warm_rst_in(warm_rst_in), .io_addr_in(io_addr_in),
        .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
        .io_rdata_out(io_rdata_out), .fdc_dor_in(fdc_dor_in),
        .fdc_we_n_in(we_n), .fdc_wd_n_in(wd_n), .fdc_high_rate_in(hi_rate),
        .wp_pin_n_in(wp_n), .prt_mode_low_in(pm_low), .motor_a_pin_out(ma),
        .motor_b_pin_out(mb), .drive_select_a_pin_out(da),
        .drive_select_b_pin_out(db), .write_enable_n_out(we_o),
        .write_data_pin_out(wd_o), .reduced_write_current_pin_out(reduced_write_current_pin),
        .floppy_pins_oe_out(oe), .write_protect_out(wp),
        .floppy_pullup_en_out(pu), .floppy_power_down_out(pwd),
        .uart_a_power_down_out(ua_pd), .uart_b_power_down_out(ub_pd),
        .uart_a_oe_out(ua_oe), .uart_b_oe_out(ub_oe),
        .par_power_down_out(p_pd), .par_oe_out(p_oe),
        .par_mode_out(par_mode), .par_mode_rsvd_out(p_rsvd),
        .ecp_fifo_level_out(ecp), .media_id_out(media),
        .boot_drive_out(boot), .drive_type_out(dtype),
        .three_mode_enable_out(tm), .config_open_out(opn));
    sioc_fdd_model drives (.four_mode_in(four), .motor_a_n_in(ma),
        .motor_b_n_in(mb), .ds_a_n_in(da), .ds_b_n_in(db), .wp_n_out(wp_n));
    // ****************************************************
    // clock, bus cycles and comparison
    // ****************************************************
    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic io_wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        io_addr_in  <= a;
        io_wdata_in <= v;
        io_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        io_wr_in    <= 1'b0;
    endtask
    task automatic io_rd(input logic [11:0] a);
        @(posedge clk_sys_in);
        io_addr_in <= a;
        io_rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        io_rd_in   <= 1'b0;
        @(posedge clk_sys_in);
        #1 d = io_rdata_out;
    endtask
    task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
        io_wr(12'h0251, i);
        io_wr(12'h0252, v);
    endtask
    task automatic reg_rd(input logic [7:0] i);
        io_wr(12'h0251, i);
        io_rd(12'h0252);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask
    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset;
        io_wr(12'h0250, 8'h89);
        for (int i = 4; i < 9; i++) begin
            reg_rd(8'(i));
            chk(d, 8'h00);
        end
        reg_rd(8'h09);
        chk(d, 8'h06);
        chk({6'h00, pu, oe}, 8'h03);
        chk({4'h0, ecp}, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_power;
        reg_wr(8'h04, 8'hFF);
        reg_rd(8'h04);
        chk(d, 8'hBB);
        chk({4'h0, ua_pd, ua_oe, p_pd, p_oe}, 8'h0A);
        chk({6'h00, ub_pd, ub_oe}, 8'h02);
        reg_wr(8'h04, 8'h30);
        settle();
        chk({6'h00, ua_pd, ua_oe}, 8'h03);
        chk({6'h00, ub_pd, ub_oe}, 8'h03);
        reg_wr(8'h04, 8'h00);
        $display("power control test done");
    endtask
    task automatic t_ecp;
        reg_wr(8'h05, 8'hFF);
        reg_rd(8'h05);
        chk(d, 8'h0F);
        chk({4'h0, ecp}, 8'h0F);
        $display("threshold test done");
    endtask
    task automatic t_drives;
        fdc_dor_in <= 8'h10;
        settle();
        chk({3'h0, wp, mb, ma, db, da}, 8'h0A);
        fdc_dor_in <= 8'h21;
        settle();
        chk({3'h0, wp, mb, ma, db, da}, 8'h15);
        reg_wr(8'h06, 8'h3A);
        four <= 1'b1;
        fdc_dor_in <= 8'h42;
        settle();
        chk({3'h0, wp, mb, ma, db, da}, 8'h02);
        chk({5'h00, oe, pu, pwd}, 8'h01);
        fdc_dor_in <= 8'h21;
        settle();
        chk({3'h0, wp, mb, ma, db, da}, 8'h11);
        fdc_dor_in <= 8'h83;
        settle();
        chk({3'h0, wp, mb, ma, db, da}, 8'h03);
        reg_wr(8'h06, 8'h00);
        four <= 1'b0;
        fdc_dor_in <= 8'h10;
        settle();
        chk({5'h00, oe, pu, pwd}, 8'h06);
        $display("drive pin test done");
    endtask
    task automatic t_write;
        we_n <= 1'b0;
        wd_n <= 1'b0;
        reg_wr(8'h08, 8'hFF);
        settle();
        chk({5'h00, we_o, wd_o, wp}, 8'h07);
        chk({4'h0, media, boot}, 8'h0F);
        reg_wr(8'h08, 8'h00);
        settle();
        chk({5'h00, we_o, wd_o, wp}, 8'h00);
        $display("write control test done");
    endtask
    task automatic t_lock;
        pm_low <= 2'b10;
        reg_wr(8'h09, 8'hC0);
        settle();
        chk({4'h0, p_rsvd, par_mode}, 8'h06);
        reg_wr(8'h05, 8'h03);
        reg_rd(8'h05);
        chk(d, 8'h00);
        reg_wr(8'h09, 8'h00);
        reg_rd(8'h05);
        chk(d, 8'h0F);
        chk({4'h0, p_rsvd, par_mode}, 8'h0A);
        $display("lock test done");
    endtask
    task automatic t_three;
        reg_wr(8'h09, 8'h20);
        reg_wr(8'h07, 8'h02);
        settle();
        chk({4'h0, tm, reduced_write_current_pin, dtype}, 8'h0E);
        io_wr(12'h03F3, 8'hFF);
        io_rd(12'h03F3);
        chk(d, 8'h30);
        io_wr(12'h03F3, 8'h10);
        settle();
        chk({7'h00, reduced_write_current_pin}, 8'h00);
        io_wr(12'h03F3, 8'h00);
        reg_wr(8'h07, 8'hE4);
        fdc_dor_in <= 8'h03;
        hi_rate <= 1'b1;
        settle();
        chk({5'h00, reduced_write_current_pin, dtype}, 8'h07);
        $display("three-mode test done");
    endtask
    task automatic t_warm;
        @(posedge clk_sys_in);
        warm_rst_in <= 1'b1;
        @(posedge clk_sys_in);
        warm_rst_in <= 1'b0;
        reg_rd(8'h05);
        chk({7'h00, opn}, 8'h00);
        chk(d, 8'h00);
        io_wr(12'h0250, 8'h89);
        reg_rd(8'h05);
        chk(d, 8'h0F);
        $display("warm reset test done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        // a hung run is cut short and judged as failed
        #100000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        t_reset();
        t_power();
        t_ecp();
        t_drives();
        t_write();
        t_lock();
        t_three();
        t_warm();
        stop_test();
    end
endmodule
`default_nettype wire
